// >>> irq_ctrl_consts.svh
// Constant offsets, codes and field positions of the interrupt command block.
`ifndef IRQ_CTRL_CONSTS_SVH
`define IRQ_CTRL_CONSTS_SVH

// =========================================================================
// Instruction codes
`define OP_ERR_CLEAR 8'h24
`define OP_IRQ_ENABLE 8'h19
`define OP_IRQ_DISABLE 8'h1a
`define OP_IRQ_VECTOR 8'h25
`define OP_IRQ_RETURN 8'h26

// =========================================================================
// Type field codes
`define TYPE_ALL_FLAGS 8'h00
`define TYPE_GLOBAL_IRQ 8'hff

// =========================================================================
// Reply status codes
`define STATUS_OK 8'h64
`define STATUS_BAD_CHECKSUM 8'h01
`define STATUS_BAD_COMMAND 8'h02

// =========================================================================
// Frame layout: byte index of the checksum and field positions in the
// 64-bit word made of the first eight bytes.
`define FRAME_LAST_IDX 4'h8
`define FLD_ADDR_HI 63
`define FLD_ADDR_LO 56
`define FLD_OP_HI 55
`define FLD_OP_LO 48
`define FLD_TYPE_HI 47
`define FLD_TYPE_LO 40
`define FLD_VALUE_HI 31
`define FLD_VALUE_LO 0

// =========================================================================
// Number of error flags
`define ERR_FLAG_COUNT 5

`endif

// >>> irq_ctrl_pkg.sv
// Types shared by the interrupt command block.
`default_nettype none
package irq_ctrl_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [31:0] word_t;
  typedef logic [4:0] err_flags_t;
  typedef logic [7:0] cpu_flags_t;
  // Source of the command executed in a cycle.
  typedef enum logic [1:0] {
    SRC_NONE = 2'b00,
    SRC_HOST = 2'b01,
    SRC_PROG = 2'b10
  } cmd_src_t;
endpackage
`default_nettype wire

// >>> error_clear_and_irq_control.sv
// Error flag clearing and interrupt command handling of a program interpreter.
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_consts.svh"

module error_clear_and_irq_control (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Module address compared with the first frame byte
  input wire logic [7:0] module_address,
  // Host frame bytes from the transport logic
  input wire logic rx_byte_valid,
  input wire logic [7:0] rx_byte,
  // Reply to the host
  output logic reply_valid,
  output logic [7:0] reply_status,
  output logic [7:0] reply_opcode,
  output logic [31:0] reply_value,
  // Commands fetched from the stored program
  input wire logic prog_cmd_valid,
  output logic prog_cmd_ready,
  input wire logic [7:0] prog_opcode,
  input wire logic [7:0] prog_type,
  input wire logic [31:0] prog_value,
  // Error events and flags
  input wire logic [4:0] err_set,
  output logic [4:0] err_flags,
  // Interrupt request from the source logic
  input wire logic irq_req,
  input wire logic [7:0] irq_num,
  output logic irq_taken,
  output logic irq_global_en,
  output logic in_handler,
  // Interpreter context, live values
  input wire logic [31:0] accu_in,
  input wire logic [31:0] xreg_in,
  input wire logic [7:0] flags_in,
  input wire logic [31:0] pc_in,
  // Jump to a handler entry point
  output logic jump_valid,
  output logic [31:0] jump_addr,
  // Context restored by a return
  output logic restore_valid,
  output logic [31:0] accu_out,
  output logic [31:0] xreg_out,
  output logic [7:0] flags_out,
  output logic [31:0] pc_out
);

  // =======================================================================
  // Reset release
  // The asynchronous reset is released through two flops so that every
  // register on rst_n leaves reset on the same clean edge.
  logic rst_meta_reg;
  logic rst_sync_reg;
  wire logic rst_n = rst_sync_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // =======================================================================
  // Frame receiver
  logic [3:0] rx_idx_reg;
  logic [7:0] rx_sum_reg;
  logic [63:0] rx_shift_reg;
  logic [63:0] cmd_reg;
  logic frame_ok_reg;
  logic frame_bad_reg;

  wire logic rx_last = (rx_idx_reg == `FRAME_LAST_IDX);
  wire logic rx_end = rx_byte_valid && rx_last;
  wire logic sum_match = (rx_sum_reg == rx_byte);
  // Frames for another module are dropped silently, bad sum or not.
  wire logic addr_match =
    (rx_shift_reg[`FLD_ADDR_HI:`FLD_ADDR_LO] == module_address);

  // byte order
  // Bytes are counted in arrival order; the ninth one is the checksum.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_idx_reg <= 4'h0;
      rx_sum_reg <= 8'h00;
      rx_shift_reg <= 64'h0;
    end else if (rx_byte_valid) begin
      if (rx_last) begin
        rx_idx_reg <= 4'h0;
        rx_sum_reg <= 8'h00;
      end else begin
        rx_idx_reg <= rx_idx_reg + 4'h1;
        rx_sum_reg <= rx_sum_reg + rx_byte;
        rx_shift_reg <= {rx_shift_reg[55:0], rx_byte};
      end
    end
  end

  // verify before use
  // The command is latched apart from the shifter, so a new frame may
  // start right behind the checksum byte.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_reg <= 64'h0;
      frame_ok_reg <= 1'b0;
      frame_bad_reg <= 1'b0;
    end else begin
      frame_ok_reg <= rx_end && addr_match && sum_match;
      frame_bad_reg <= rx_end && addr_match && !sum_match;
      if (rx_end) begin
        cmd_reg <= rx_shift_reg;
      end
    end
  end

  // =======================================================================
  // Command source selection
  // A host command has priority; the program fetch waits one cycle.
  irq_ctrl_pkg::cmd_src_t src;
  wire logic host_go = frame_ok_reg;
  wire logic prog_go = prog_cmd_valid && !host_go;
  assign prog_cmd_ready = !host_go;
  assign src = host_go ? irq_ctrl_pkg::SRC_HOST :
               prog_go ? irq_ctrl_pkg::SRC_PROG : irq_ctrl_pkg::SRC_NONE;

  wire logic go = (src != irq_ctrl_pkg::SRC_NONE);
  wire logic [7:0] ex_op =
    host_go ? cmd_reg[`FLD_OP_HI:`FLD_OP_LO] : prog_opcode;
  wire logic [7:0] ex_type =
    host_go ? cmd_reg[`FLD_TYPE_HI:`FLD_TYPE_LO] : prog_type;
  wire logic [31:0] ex_value =
    host_go ? cmd_reg[`FLD_VALUE_HI:`FLD_VALUE_LO] : prog_value;

  // =======================================================================
  // Command decode
  wire logic is_cle = (ex_op == `OP_ERR_CLEAR);
  wire logic is_en = (ex_op == `OP_IRQ_ENABLE);
  wire logic is_dis = (ex_op == `OP_IRQ_DISABLE);
  wire logic is_vec = (ex_op == `OP_IRQ_VECTOR);
  wire logic is_ret = (ex_op == `OP_IRQ_RETURN);
  wire logic known = is_cle || is_en || is_dis || is_vec || is_ret;
  wire logic type_global = (ex_type == `TYPE_GLOBAL_IRQ);

  // =======================================================================
  // Error flags
  irq_ctrl_pkg::err_flags_t err_flags_reg;
  irq_ctrl_pkg::err_flags_t err_flags_next;
  // A net, since each bit has a continuous assignment of its own.
  wire irq_ctrl_pkg::err_flags_t clr_sel;
  irq_ctrl_pkg::err_flags_t clr_mask;

  // type decode
  // Type 1 selects bit 0 (timeout) up to type 5 for bit 4 (shutdown).
  genvar fi;
  generate
    for (fi = 0; fi < `ERR_FLAG_COUNT; fi++) begin : g_clr
      assign clr_sel[fi] = (ex_type == 8'(fi + 1));
    end
  endgenerate
  assign clr_mask = (go && is_cle) ?
    ((ex_type == `TYPE_ALL_FLAGS) ? 5'h1f : clr_sel) : 5'h00;
  // An error event in the clearing cycle survives: the set wins.
  assign err_flags_next = (err_flags_reg & ~clr_mask) | err_set;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      err_flags_reg <= 5'h00;
    end else begin
      err_flags_reg <= err_flags_next;
    end
  end
  assign err_flags = err_flags_reg;

  // =======================================================================
  // Interrupt enables
  logic [255:0] src_en_reg;
  logic global_en_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      src_en_reg <= 256'h0;
      global_en_reg <= 1'b0;
    end else if (go && (is_en || is_dis)) begin
      if (type_global) begin
        global_en_reg <= is_en;
      end else begin
        src_en_reg[ex_type] <= is_en;
      end
    end
  end
  assign irq_global_en = global_en_reg;

  // =======================================================================
  // Vector table
  // The table holds no reset; a valid bit per entry keeps an undefined
  // vector from ever being taken.
  logic [31:0] vec_mem [0:255];
  logic [255:0] vec_valid_reg;
  wire logic vec_we = go && is_vec;

  always_ff @(posedge clk) begin
    if (vec_we) begin
      vec_mem[ex_type] <= ex_value;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vec_valid_reg <= 256'h0;
    end else if (vec_we) begin
      vec_valid_reg[ex_type] <= 1'b1;
    end
  end

  // =======================================================================
  // Handler entry and return
  logic in_handler_reg;
  logic [31:0] save_accu_reg;
  logic [31:0] save_xreg_reg;
  logic [7:0] save_flags_reg;
  logic [31:0] save_pc_reg;

  wire logic ret_go = go && is_ret && in_handler_reg;
  // Handlers do not nest; a request blocked here is dropped, and the
  // source sees that irq_taken stayed low.
  wire logic take = irq_req && global_en_reg && src_en_reg[irq_num] &&
    vec_valid_reg[irq_num] && !in_handler_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_handler_reg <= 1'b0;
      save_accu_reg <= 32'h0;
      save_xreg_reg <= 32'h0;
      save_flags_reg <= 8'h00;
      save_pc_reg <= 32'h0;
    end else if (take) begin
      in_handler_reg <= 1'b1;
      save_accu_reg <= accu_in;
      save_xreg_reg <= xreg_in;
      save_flags_reg <= flags_in;
      save_pc_reg <= pc_in;
    end else if (ret_go) begin
      in_handler_reg <= 1'b0;
    end
  end
  assign in_handler = in_handler_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      jump_valid <= 1'b0;
      jump_addr <= 32'h0;
      irq_taken <= 1'b0;
    end else begin
      jump_valid <= take;
      irq_taken <= take;
      if (take) begin
        jump_addr <= vec_mem[irq_num];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      restore_valid <= 1'b0;
      accu_out <= 32'h0;
      xreg_out <= 32'h0;
      flags_out <= 8'h00;
      pc_out <= 32'h0;
    end else begin
      restore_valid <= ret_go;
      if (ret_go) begin
        accu_out <= save_accu_reg;
        xreg_out <= save_xreg_reg;
        flags_out <= save_flags_reg;
        pc_out <= save_pc_reg;
      end
    end
  end

  // =======================================================================
  // Host reply
  // Only host frames are answered; program commands run without reply.
  wire logic reply_go = host_go || frame_bad_reg;
  wire logic [7:0] status_sel = frame_bad_reg ? `STATUS_BAD_CHECKSUM :
    (known ? `STATUS_OK : `STATUS_BAD_COMMAND);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reply_valid <= 1'b0;
      reply_status <= 8'h00;
      reply_opcode <= 8'h00;
      reply_value <= 32'h0;
    end else begin
      reply_valid <= reply_go;
      if (reply_go) begin
        reply_status <= status_sel;
        reply_opcode <= cmd_reg[`FLD_OP_HI:`FLD_OP_LO];
        reply_value <= 32'h0;
      end
    end
  end

endmodule
`default_nettype wire

// >>> irq_ctrl_checker_assertions.sv
// Port-level checks of the interrupt command block.
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_consts.svh"
// ==========
// Checker
module irq_ctrl_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Watched ports
  input wire logic reply_valid,
  input wire logic [31:0] reply_value,
  input wire logic prog_cmd_valid,
  input wire logic prog_cmd_ready,
  input wire logic [7:0] prog_opcode,
  input wire logic [4:0] err_set,
  input wire logic [4:0] err_flags,
  input wire logic irq_req,
  input wire logic irq_taken,
  input wire logic irq_global_en,
  input wire logic in_handler,
  input wire logic jump_valid,
  input wire logic [31:0] jump_addr,
  input wire logic restore_valid
);
  // One domain, so clock and reset are stated once.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_reply_one_pulse: assert property (reply_valid |=> !reply_valid)
    else $error("reply pulse too long");
  a_reply_value_zero: assert property (reply_valid |-> !reply_value)
    else $error("reply value not zero");
  a_exec_then_reply: assert property (!prog_cmd_ready |=> reply_valid)
    else $error("host command without reply");
  a_entry_cause: assert property
    (irq_taken |-> $past(irq_req && irq_global_en && !in_handler))
    else $error("entry without a permitted request");
  a_entry_pair: assert property (irq_taken |-> jump_valid && in_handler)
    else $error("entry pulses not paired");
  a_restore_exit: assert property
    (restore_valid |-> $past(in_handler) && !in_handler)
    else $error("restore outside a handler");
  a_flag_set_sticky: assert property
    (|err_set |=> (err_flags & $past(err_set)) == $past(err_set))
    else $error("error flag not set");
  a_flag_clear_cause: assert property
    (|($past(err_flags) & ~err_flags) |-> $past(!prog_cmd_ready ||
      (prog_cmd_valid && prog_opcode == `OP_ERR_CLEAR)))
    else $error("error flag cleared without command");
  a_global_cause: assert property
    ($changed(irq_global_en) |-> $past(!prog_cmd_ready || prog_cmd_valid))
    else $error("global enable moved by itself");
  a_jump_addr_hold: assert property (!jump_valid |-> $stable(jump_addr))
    else $error("jump address moved without jump");
endmodule
bind error_clear_and_irq_control irq_ctrl_checker irq_ctrl_checker_inst (
  .clk, .reset_n, .reply_valid, .reply_value, .prog_cmd_valid,
  .prog_cmd_ready, .prog_opcode, .err_set, .err_flags, .irq_req,
  .irq_taken, .irq_global_en, .in_handler, .jump_valid, .jump_addr,
  .restore_valid);
`default_nettype wire

// >>> host_model.sv
// Host model that sends command frames byte by byte.
`timescale 1ns/1ps
`default_nettype none
// ==========
// Host
module host_model (
  // Clock
  input wire logic clk,
  // Frame bytes
  output logic rx_byte_valid,
  output logic [7:0] rx_byte
);
  // Idle line at time zero.
  initial begin
    rx_byte_valid = 1'b0;
    rx_byte = 8'h00;
  end
  // Sends one frame; gap idles between bytes, bad spoils the sum.
  task automatic send(input logic [7:0] a, op, t, b, input logic [31:0] v,
    input logic bad, input int gap);
    logic [7:0] f [9];
    f = '{a, op, t, b, v[31:24], v[23:16], v[15:8], v[7:0], 8'h00};
    for (int i = 0; i < 8; i++) f[8] += f[i];
    f[8] ^= {7'h00, bad};
    for (int i = 0; i < 9; i++) begin
      repeat (gap) begin
        @(negedge clk);
        rx_byte_valid = 1'b0;
      end
      @(negedge clk);
      rx_byte_valid = 1'b1;
      rx_byte = f[i];
    end
    @(negedge clk);
    rx_byte_valid = 1'b0;
    rx_byte = ~rx_byte; // No stale byte on an idle line.
  endtask
endmodule
`default_nettype wire

// >>> testbench.sv
// Self-checking bench of the interrupt command block.
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_consts.svh"
// ==========
// Bench
module testbench;
  logic clk, reset_n, rx_byte_valid, prog_cmd_valid, irq_req;
  logic reply_valid, prog_cmd_ready, irq_taken, irq_global_en, in_handler;
  logic jump_valid, restore_valid;
  logic [7:0] rx_byte, reply_status, reply_opcode, prog_opcode, prog_type;
  logic [7:0] irq_num, flags_in, flags_out;
  logic [4:0] err_set, err_flags;
  logic [31:0] reply_value, prog_value, accu_in, xreg_in, pc_in, jump_addr;
  logic [31:0] accu_out, xreg_out, pc_out;
  int mismatches, num_checks, cycles;
  error_clear_and_irq_control error_clear_and_irq_control_inst (.clk,
    .reset_n, .module_address(8'h01), .rx_byte_valid, .rx_byte,
    .reply_valid, .reply_status, .reply_opcode, .reply_value,
    .prog_cmd_valid, .prog_cmd_ready, .prog_opcode, .prog_type, .prog_value,
    .err_set, .err_flags, .irq_req, .irq_num, .irq_taken, .irq_global_en,
    .in_handler, .accu_in, .xreg_in, .flags_in, .pc_in, .jump_valid,
    .jump_addr, .restore_valid, .accu_out, .xreg_out, .flags_out, .pc_out);
  host_model host_model_inst (.clk, .rx_byte_valid, .rx_byte);
  // Clock of 20 ns; a hang counts as a mismatch.
  always #10 clk = ~clk;
  always @(posedge clk) if (++cycles == 3000) begin
    mismatches++;
    test_done();
  end
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Host frame, then the reply in the cycle after the execute cycle.
  task automatic cmd(input logic [7:0] a, op, t, input logic [31:0] v,
    input logic bad, input int gap, input logic rv, input logic [7:0] st);
    host_model_inst.send(a, op, t, 8'h5a, v, bad, gap);
    // Execute cycle: only a good frame for this module holds off programs.
    chk(prog_cmd_ready, !rv || st == `STATUS_BAD_CHECKSUM);
    @(negedge clk);
    chk(reply_valid, rv);
    if (rv) chk({reply_status, reply_opcode}, {st, op});
    if (rv) chk(reply_value, 32'h0);
  endtask
  // Program command taken at the edge between two falling edges.
  task automatic prog(input logic [7:0] op, t);
    @(negedge clk);
    {prog_cmd_valid, prog_opcode, prog_type} = {1'b1, op, t};
    @(negedge clk);
    {prog_cmd_valid, prog_opcode, prog_type} = {1'b0, ~op, ~t};
  endtask
  task automatic pulse(input logic [4:0] e, input logic r, input logic [7:0] n);
    @(negedge clk);
    {err_set, irq_req, irq_num} = {e, r, n};
    @(negedge clk);
    {err_set, irq_req, irq_num} = {5'h00, 1'b0, ~n};
  endtask
  task automatic t_clear;
    for (int k = 0; k < 6; k++) begin
      pulse(5'h1f, 1'b0, 8'h00);
      cmd(8'h01, `OP_ERR_CLEAR, k, 32'hdeadbeef, 0, 0, 1, `STATUS_OK);
      chk(err_flags, k ? 32'h1f ^ (32'h1 << (k - 1)) : 32'h0);
    end
    pulse(5'h1f, 1'b0, 8'h00);
    prog(`OP_ERR_CLEAR, 8'h03);
    chk(err_flags, 32'h1b);
  endtask
  task automatic t_refuse;
    cmd(8'h01, `OP_ERR_CLEAR, 8'h00, 0, 1, 0, 1, `STATUS_BAD_CHECKSUM);
    chk(err_flags, 32'h1b);
    cmd(8'h07, `OP_ERR_CLEAR, 8'h00, 0, 0, 2, 0, 8'h00);
    chk(err_flags, 32'h1b);
    // An unknown instruction is answered but changes nothing.
    cmd(8'h01, 8'h30, 8'h00, 0, 0, 0, 1, `STATUS_BAD_COMMAND);
    chk(err_flags, 32'h1b);
  endtask
  task automatic t_irq;
    // handler label in the value field
    cmd(8'h01, `OP_IRQ_VECTOR, 8'h03, 32'h50, 0, 1, 1, `STATUS_OK);
    cmd(8'h01, `OP_IRQ_VECTOR, 8'h03, 32'h77, 0, 0, 1, `STATUS_OK);
    prog(`OP_IRQ_ENABLE, 8'h03);
    cmd(8'h01, `OP_IRQ_ENABLE, 8'hff, 0, 0, 0, 1, `STATUS_OK);
    chk(irq_global_en, 1);
    {accu_in, xreg_in, flags_in, pc_in} = {32'h11, 32'h22, 8'h33, 32'h44};
    pulse(5'h00, 1'b1, 8'h03);
    chk({irq_taken, jump_valid, in_handler}, 32'h7);
    chk(jump_addr, 32'h77);
    {accu_in, xreg_in, flags_in, pc_in} = '1;
    prog(`OP_IRQ_RETURN, 8'hff);
    chk({restore_valid, in_handler}, 32'h2);
    chk(accu_out, 32'h11);
    chk(xreg_out, 32'h22);
    chk(flags_out, 32'h33);
    chk(pc_out, 32'h44);
    cmd(8'h01, `OP_IRQ_DISABLE, 8'hff, 0, 0, 0, 1, `STATUS_OK);
    pulse(5'h00, 1'b1, 8'h03);
    chk({irq_taken, irq_global_en}, 32'h0);
    cmd(8'h01, `OP_IRQ_ENABLE, 8'hff, 0, 0, 0, 1, `STATUS_OK);
    prog(`OP_IRQ_DISABLE, 8'h03);
    pulse(5'h00, 1'b1, 8'h03);
    chk({irq_taken, irq_global_en}, 32'h1);
  endtask
  // Reset for three cycles, then wait out the internal release.
  initial begin
    {clk, reset_n, prog_cmd_valid, irq_req, err_set, irq_num} = '0;
    {prog_opcode, prog_type, prog_value} = '0;
    {accu_in, xreg_in, flags_in, pc_in} = '0;
    {mismatches, num_checks, cycles} = '0;
    repeat (3) @(negedge clk);
    reset_n = 1'b1;
    repeat (4) @(negedge clk);
    t_clear();
    t_refuse();
    t_irq();
    test_done();
  end
endmodule
`default_nettype wire
